//--- dv/parallel_nvram_interface_test.sv
// Self-checking bench for the nonvolatile memory host controller
`timescale 1ns/1ns
`default_nettype none
module parallel_nvram_interface_test;
    logic        clk_sys_i = 1'b0, rstn_i = 1'b0, req_i = 1'b0, write_i = 1'b0;
    logic        keep_open_i = 1'b0, sleep_i = 1'b0;
    logic [16:0] addr_i = 17'h00000, a, wal;
    logic [15:0] wdata_i = 16'h0000, rdata_o, dl_i, dl_o, dev_q;
    logic [1:0]  byte_en_i = 2'h3, dl_oe;
    logic        ready_o, ack_o, asleep_o, cs_n, we_n, oe_n, ub_n, lb_n, slp_n;
    logic [15:0] ref_mem [int];
    logic [31:0] seed;
    int          n_mismatch = 0, n_compared = 0, open_row = -1, i;
    always #5 clk_sys_i = ~clk_sys_i;
    // Wire level per lane: host when it drives, else the device side
    assign dl_i = {dl_oe[1] ? dl_o[15:8] : dev_q[15:8], dl_oe[0] ? dl_o[7:0] : dev_q[7:0]};
    pni_host pni_host_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i),
        .write_i(write_i), .keep_open_i(keep_open_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .byte_en_i(byte_en_i), .sleep_i(sleep_i), .ready_o(ready_o), .ack_o(ack_o),
        .rdata_o(rdata_o), .asleep_o(asleep_o), .word_address_lines_o(wal),
        .chip_select_n_o(cs_n), .write_strobe_n_o(we_n), .output_drive_n_o(oe_n),
        .upper_byte_select_n_o(ub_n), .lower_byte_select_n_o(lb_n), .sleep_request_n_o(slp_n),
        .data_lines_i(dl_i), .data_lines_o(dl_o), .data_lines_oe_o(dl_oe));
    pni_mem_model pni_mem_model_inst (.word_address_lines_i(wal), .chip_select_n_i(cs_n),
        .write_strobe_n_i(we_n), .output_drive_n_i(oe_n), .upper_byte_select_n_i(ub_n),
        .lower_byte_select_n_i(lb_n), .sleep_request_n_i(slp_n), .data_lines_i(dl_i),
        .data_lines_o(dev_q));
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : cmp_data
    // Negedges counted from the take edge: one more than the edges to ack
    task automatic cmp_count(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            n_mismatch++;
            $display("mismatch at %0t: latency %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_count
    // One request held until ack; reads checked against the reference array, writes stored in it
    task automatic access(input logic w, input logic k, input logic [16:0] ad,
                          input logic [15:0] d, input logic [1:0] be);
        int t;
        int lat;
        logic [15:0] e;
        e = ref_mem.exists(ad) ? ref_mem[ad] : 16'h0000;
        lat = (open_row == int'(ad[16:2])) ? pni_pkg::PAGE_CYC : pni_pkg::ACC_CYC;
        lat = 2 + lat + (w ? 1 : pni_pkg::SYNC_STAGES);
        if (open_row >= 0 && open_row != int'(ad[16:2])) lat = -1;
        @(posedge clk_sys_i);
        req_i <= 1'b1;
        write_i <= w;
        keep_open_i <= k;
        addr_i <= ad;
        wdata_i <= d;
        byte_en_i <= be;
        @(negedge clk_sys_i);
        for (t = 0; t < 400 && ready_o !== 1'b1; t++) @(negedge clk_sys_i);
        if (ready_o !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: ready never shown", $time);
        end
        @(posedge clk_sys_i);
        t = 0;
        do begin
            @(negedge clk_sys_i);
            t++;
        end while (ack_o !== 1'b1 && t < 400);
        if (ack_o !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: no ack", $time);
        end
        if (lat > 0) cmp_count(t, lat);
        if (w) begin
            if (be[1]) e[15:8] = d[15:8];
            if (be[0]) e[7:0] = d[7:0];
            ref_mem[ad] = e;
        end else begin
            cmp_data(rdata_o, {be[1] ? e[15:8] : 8'h00, be[0] ? e[7:0] : 8'h00});
        end
        open_row = k ? int'(ad[16:2]) : -1;
        @(posedge clk_sys_i);
        req_i <= 1'b0;
    endtask : access
    // Watchdog: the whole sequence needs well under 100 us
    initial begin
        #100000;
        n_mismatch++;
        final_report();
    end
    // Main sequence
    initial begin
        seed = $urandom(32'h207F266A);
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(negedge clk_sys_i);
        cmp_data({10'h000, cs_n, we_n, oe_n, ub_n, lb_n, slp_n}, 16'h003F);
        for (i = 0; i < 8; i++) begin
            a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : 17'($urandom);
            access(1'b1, 1'b0, a, 16'($urandom), 2'h3);
            access(1'b0, 1'b0, a, 16'h0000, 2'h3);
        end
        access(1'b1, 1'b0, a, 16'($urandom), 2'h1);
        access(1'b1, 1'b0, a, 16'($urandom), 2'h2);
        for (i = 1; i < 4; i++) access(1'b0, 1'b0, a, 16'h0000, 2'(i));
        for (i = 0; i < 8; i++) access(i < 4, i != 7, {a[16:2], 2'(i)}, 16'($urandom), 2'h3);
        access(1'b1, 1'b1, a, 16'($urandom), 2'h3);
        access(1'b0, 1'b0, 17'h00000, 16'h0000, 2'h3);
        @(posedge clk_sys_i);
        sleep_i <= 1'b1;
        for (i = 0; i < 20 && asleep_o !== 1'b1; i++) @(negedge clk_sys_i);
        cmp_data({13'h0000, asleep_o, slp_n, ready_o}, 16'h0004);
        @(posedge clk_sys_i);
        sleep_i <= 1'b0;
        access(1'b0, 1'b0, 17'h1FFFF, 16'h0000, 2'h3);
        final_report();
    end
endmodule : parallel_nvram_interface_test
`default_nettype wire

//--- dv/pni_host_asserts.sv
// Assertions on the pins and handshake of the nonvolatile memory host
`timescale 1ns/1ns
`default_nettype none
module pni_host_asserts (
    // Clock and reset
    input wire logic                       clk_sys_i,
    input wire logic                       rstn_i,
    // Handshake
    input wire logic                       req_i,
    input wire logic                       ready_o,
    input wire logic                       ack_o,
    // Memory pins
    input wire logic [pni_pkg::ADDR_W-1:0] word_address_lines_o,
    input wire logic                       chip_select_n_o,
    input wire logic                       write_strobe_n_o,
    input wire logic                       output_drive_n_o,
    input wire logic                       upper_byte_select_n_o,
    input wire logic                       lower_byte_select_n_o,
    input wire logic                       sleep_request_n_o,
    input wire logic [1:0]                 data_lines_oe_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // ********
    // Access steps
    // ********
    sequence sel_fall_s; $fell(chip_select_n_o); endsequence
    sequence word_write_s; sel_fall_s ##0 !write_strobe_n_o; endsequence
    sequence page_write_s; $fell(write_strobe_n_o) ##0 !$past(chip_select_n_o); endsequence
    ack_pulse_a: assert property (ack_o |-> !ready_o ##1 !ack_o) else $error("ack not a pulse");
    take_busy_a: assert property (req_i && ready_o |=> !ready_o) else $error("busy not shown");
    sel_hold_a: assert property (sel_fall_s |-> !chip_select_n_o [*6]) else $error("short select");
    addr_setup_a: assert property (sel_fall_s |-> $stable(word_address_lines_o)) else $error("addr moved");
    word_write_a: assert property (word_write_s |-> !write_strobe_n_o [*6]) else $error("short write");
    page_write_a: assert property (page_write_s |-> !write_strobe_n_o [*3]) else $error("short page");
    strobe_sel_a: assert property (!write_strobe_n_o |-> !chip_select_n_o && output_drive_n_o)
        else $error("strobe outside select");
    drive_float_a: assert property (data_lines_oe_o != 2'h0 |-> output_drive_n_o)
        else $error("bus contention");
    lane_sel_a: assert property (data_lines_oe_o[1] && !upper_byte_select_n_o || !data_lines_oe_o[1])
        else $error("upper lane unselected");
    lane_low_a: assert property (data_lines_oe_o[0] |-> !lower_byte_select_n_o)
        else $error("lower lane unselected");
    precharge_a: assert property ($rose(chip_select_n_o) |-> chip_select_n_o [*3]) else $error("short precharge");
    row_hold_a: assert property (!chip_select_n_o && !$past(chip_select_n_o)
        |-> $stable(word_address_lines_o[pni_pkg::ADDR_W-1:pni_pkg::COL_W])) else $error("row moved");
    sleep_quiet_a: assert property (!sleep_request_n_o |-> chip_select_n_o && write_strobe_n_o)
        else $error("access in sleep");
endmodule : pni_host_asserts
bind pni_host pni_host_asserts pni_host_asserts_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .req_i(req_i), .ready_o(ready_o), .ack_o(ack_o), .word_address_lines_o(word_address_lines_o),
    .chip_select_n_o(chip_select_n_o), .write_strobe_n_o(write_strobe_n_o),
    .output_drive_n_o(output_drive_n_o), .upper_byte_select_n_o(upper_byte_select_n_o),
    .lower_byte_select_n_o(lower_byte_select_n_o), .sleep_request_n_o(sleep_request_n_o),
    .data_lines_oe_o(data_lines_oe_o));
`default_nettype wire

//--- dv/pni_mem_model.sv
// Behavioural model of the parallel nonvolatile memory device
`timescale 1ns/1ns
`default_nettype none
module pni_mem_model #(
    parameter int ACC_NS  = 59,
    parameter int PAGE_NS = 29
) (
    // Memory pins
    input  wire logic [16:0] word_address_lines_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        write_strobe_n_i,
    input  wire logic        output_drive_n_i,
    input  wire logic        upper_byte_select_n_i,
    input  wire logic        lower_byte_select_n_i,
    input  wire logic        sleep_request_n_i,
    input  wire logic [15:0] data_lines_i,
    output var  logic [15:0] data_lines_o
);
    logic [15:0] mem [int];
    logic [15:0] rd, w;
    logic [14:0] row = 15'h0000;
    logic [1:0]  wcol = 2'h0;
    logic        vld = 1'b0, sel = 1'b0, drv;
    int          n_chg = 0, dly;
    // Access timer restarts on select fall or address change; same row is faster
    always @(word_address_lines_i or chip_select_n_i) begin
        n_chg = n_chg + 1;
        vld = 1'b0;
        dly = (sel && !chip_select_n_i && word_address_lines_i[16:2] == row) ? PAGE_NS : ACC_NS;
        row = word_address_lines_i[16:2];
        sel = !chip_select_n_i;
        fork
            automatic int k = n_chg;
            automatic int d = dly;
            begin
                #(d);
                if (k == n_chg && !chip_select_n_i) vld = 1'b1;
            end
        join_none
    end
    // Column taken at strobe fall for page writes
    always @(negedge write_strobe_n_i) wcol = word_address_lines_i[1:0];
    // Commit at whichever of strobe or select rises first, per lane
    always @(posedge write_strobe_n_i or posedge chip_select_n_i) begin
        if (sleep_request_n_i && (chip_select_n_i ^ write_strobe_n_i)) begin
            w = mem.exists({row, wcol}) ? mem[{row, wcol}] : 16'h0000;
            if (!upper_byte_select_n_i) w[15:8] = data_lines_i[15:8];
            if (!lower_byte_select_n_i) w[7:0] = data_lines_i[7:0];
            mem[{row, wcol}] = w;
        end
    end
    // Only valid data is driven; a floating lane shows the inverse pattern
    assign drv = vld && !output_drive_n_i && write_strobe_n_i && sleep_request_n_i;
    always @(word_address_lines_i, drv, upper_byte_select_n_i, lower_byte_select_n_i) begin
        rd = mem.exists(word_address_lines_i) ? mem[word_address_lines_i] : 16'h0000;
        data_lines_o[15:8] = (drv && !upper_byte_select_n_i) ? rd[15:8] : ~rd[15:8];
        data_lines_o[7:0] = (drv && !lower_byte_select_n_i) ? rd[7:0] : ~rd[7:0];
    end
endmodule : pni_mem_model
`default_nettype wire

//--- include/pni_pkg.sv
// Constants and types shared by the parallel nonvolatile memory host controller
//
// Overview of operation
// R1 - 17-bit word address selects one word
// R2 - Two low address bits are page column
// R3 - One 16-bit two-way data bus
// R4 - Write strobe low starts, rising edge commits
// R5 - Strobe falling edge takes new column address
// R6 - Chip select fall latches full address
// R7 - Chip select low: only column bits change
// R8 - Device drives bus only with valid data
// R9 - Output drive high floats data bus
// R10 - Byte selects gate upper and lower lanes
// R11 - Byte selects allow byte-wide organisation
// R12 - Byte selects may stay low permanently
// R13 - Sleep input low enters sleep state
// R14 - Host keeps sleep high for accesses
// R15 - Read starts on select fall or address
// R16 - Write started by select or strobe
// R17 - 60 ns access, 90 ns cycle, 30 ns page
// R18 - Strobe low: device leaves bus undriven
// R19 - Select high for precharge minimum interval
// R20 - Row change closes row, precharges automatically
package pni_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int COL_W  = 2;
    localparam int ROW_W  = ADDR_W - COL_W;
    localparam int LANE_W = 8;
    localparam int CNT_W  = 8;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // Timing, in ns, and derived clock counts
    // ************************************************************
    localparam int CLK_MHZ      = 100;
    localparam int ACCESS_NS    = 60;
    localparam int CYCLE_NS     = 90;
    localparam int PAGE_NS      = 30;
    localparam int PRECHARGE_NS = 30;    // Plain default, not printed
    localparam int WAKE_NS      = 1000;  // Plain default, not printed

    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] ACC_CYC  = CNT_W'((ACCESS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] PAGE_CYC = CNT_W'((PAGE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CYC_CYC  = CNT_W'((CYCLE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] PC_MIN   = CNT_W'((PRECHARGE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] WAKE_CYC = CNT_W'((WAKE_NS * CLK_MHZ + 999) / 1000);
    // Precharge also stretches so that random cycles meet the cycle time
    localparam logic [CNT_W-1:0] PC_CYC   = (CYC_CYC - ACC_CYC > PC_MIN) ?
                                            CYC_CYC - ACC_CYC : PC_MIN;
    localparam logic [CNT_W-1:0] SYNC_CYC = CNT_W'(SYNC_STAGES);
    localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;

    // ************************************************************
    // Controller states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_ACCESS = 3'b010,
        ST_HOLD   = 3'b011,
        ST_OPEN   = 3'b100,
        ST_PRECH  = 3'b101,
        ST_SLEEP  = 3'b110,
        ST_WAKE   = 3'b111
    } pni_state_t;

endpackage : pni_pkg

//--- logic/pni_host.sv
// Host controller driving the parallel nonvolatile memory pins
`timescale 1ns/1ns
`default_nettype none
module pni_host (
    // Clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rstn_i,
    // Request port
    input  wire logic                        req_i,
    input  wire logic                        write_i,
    input  wire logic                        keep_open_i,
    input  wire logic [pni_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [pni_pkg::DATA_W-1:0]  wdata_i,
    input  wire logic [1:0]                  byte_en_i,
    input  wire logic                        sleep_i,
    // Answer port
    output var  logic                        ready_o,
    output var  logic                        ack_o,
    output var  logic [pni_pkg::DATA_W-1:0]  rdata_o,
    output var  logic                        asleep_o,
    // Memory pins
    output var  logic [pni_pkg::ADDR_W-1:0]  word_address_lines_o,
    output var  logic                        chip_select_n_o,
    output var  logic                        write_strobe_n_o,
    output var  logic                        output_drive_n_o,
    output var  logic                        upper_byte_select_n_o,
    output var  logic                        lower_byte_select_n_o,
    output var  logic                        sleep_request_n_o,
    input  wire logic [pni_pkg::DATA_W-1:0]  data_lines_i,
    output var  logic [pni_pkg::DATA_W-1:0]  data_lines_o,
    output var  logic [1:0]                  data_lines_oe_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pni_pkg::pni_state_t         state;
        logic [pni_pkg::CNT_W-1:0]   cnt;
        logic                        is_write;
        logic                        keep;
        logic                        ready;
        logic                        ack;
        logic [pni_pkg::DATA_W-1:0]  rdata;
        logic [pni_pkg::ADDR_W-1:0]  addr;
        logic                        cs_n;
        logic                        we_n;
        logic                        oe_n;
        logic                        ub_n;
        logic                        lb_n;
        logic                        sleep_n;
        logic [pni_pkg::DATA_W-1:0]  wdata;
        logic [1:0]                  doe;
    } pni_regs_t;

    pni_regs_t                    cur;
    pni_regs_t                    next_cur;
    logic [pni_pkg::DATA_W-1:0]   data_sync;
    logic                         take;
    logic                         same_row;

    // ************************************************************
    // Pin input synchroniser
    // ************************************************************
    pni_sync #(
        .WIDTH (pni_pkg::DATA_W)
    ) u_data_sync (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .d_i       (data_lines_i),
        .q_o       (data_sync)
    );

    // Request is taken only while ready is shown
    assign take     = req_i && cur.ready;
    assign same_row = (addr_i[pni_pkg::ADDR_W-1:pni_pkg::COL_W]
                       == cur.addr[pni_pkg::ADDR_W-1:pni_pkg::COL_W]);

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        next_cur     = cur;
        next_cur.ack = 1'b0;
        unique case (cur.state)
            // Bus parked, select high, sleep honoured before any access
            pni_pkg::ST_IDLE: begin
                if (sleep_i) begin
                    next_cur.sleep_n = 1'b0;                      // R13
                    next_cur.state   = pni_pkg::ST_SLEEP;
                end else if (take) begin
                    next_cur.addr     = addr_i;                   // R1
                    next_cur.wdata    = wdata_i;
                    next_cur.is_write = write_i;
                    next_cur.keep     = keep_open_i;
                    next_cur.ub_n     = ~byte_en_i[1];            // R10
                    next_cur.lb_n     = ~byte_en_i[0];            // R11
                    next_cur.state    = pni_pkg::ST_SETUP;
                end
            end
            // Address settled one cycle before the select or strobe edge
            pni_pkg::ST_SETUP: begin
                // Page access when the select is already low
                next_cur.cnt = cur.cs_n ? pni_pkg::ACC_CYC : pni_pkg::PAGE_CYC;  // R17
                if (!cur.is_write) begin
                    next_cur.cnt = next_cur.cnt + pni_pkg::SYNC_CYC;
                end
                next_cur.cs_n  = 1'b0;                            // R6
                next_cur.we_n  = ~cur.is_write;                   // R4 R5 R16
                next_cur.oe_n  = cur.is_write;                    // R15 R18
                next_cur.doe   = cur.is_write ? {~cur.ub_n, ~cur.lb_n} : 2'b00;  // R3
                next_cur.state = pni_pkg::ST_ACCESS;
            end
            // Wait out the access time, plus synchroniser delay for reads
            pni_pkg::ST_ACCESS: begin
                next_cur.cnt = cur.cnt - pni_pkg::CNT_ONE;
                if (cur.cnt == pni_pkg::CNT_ONE) begin
                    if (cur.is_write) begin
                        next_cur.we_n  = 1'b1;                    // R4
                        next_cur.state = pni_pkg::ST_HOLD;
                    end else begin
                        // Lanes not selected float, so keep them zero
                        next_cur.rdata = data_sync & {{pni_pkg::LANE_W{~cur.ub_n}},
                                                      {pni_pkg::LANE_W{~cur.lb_n}}};  // R8 R10
                        next_cur.ack   = 1'b1;
                        next_cur.oe_n  = 1'b1;                    // R9
                        if (cur.keep) begin
                            next_cur.state = pni_pkg::ST_OPEN;
                        end else begin
                            next_cur.cs_n  = 1'b1;                // R19
                            next_cur.cnt   = pni_pkg::PC_CYC;
                            next_cur.state = pni_pkg::ST_PRECH;
                        end
                    end
                end
            end
            // Data held one cycle past the strobe's rising edge
            pni_pkg::ST_HOLD: begin
                next_cur.doe = 2'b00;
                next_cur.ack = 1'b1;
                if (cur.keep) begin
                    next_cur.state = pni_pkg::ST_OPEN;
                end else begin
                    next_cur.cs_n  = 1'b1;                        // R19
                    next_cur.cnt   = pni_pkg::PC_CYC;
                    next_cur.state = pni_pkg::ST_PRECH;
                end
            end
            // Row open with select low; same-row requests change the column only
            pni_pkg::ST_OPEN: begin
                if (sleep_i || (take && !same_row)) begin
                    // Close the row ourselves rather than lean on the auto precharge
                    next_cur.cs_n  = 1'b1;                        // R19 R20
                    next_cur.cnt   = pni_pkg::PC_CYC;
                    next_cur.state = pni_pkg::ST_PRECH;
                end else if (take) begin
                    next_cur.addr[pni_pkg::COL_W-1:0] = addr_i[pni_pkg::COL_W-1:0];  // R2 R7
                    next_cur.wdata    = wdata_i;
                    next_cur.is_write = write_i;
                    next_cur.keep     = keep_open_i;
                    next_cur.ub_n     = ~byte_en_i[1];            // R10
                    next_cur.lb_n     = ~byte_en_i[0];            // R12
                    next_cur.state    = pni_pkg::ST_SETUP;
                end
            end
            // Select held high for the precharge interval
            pni_pkg::ST_PRECH: begin
                next_cur.cnt = cur.cnt - pni_pkg::CNT_ONE;
                if (cur.cnt == pni_pkg::CNT_ONE) begin
                    next_cur.state = pni_pkg::ST_IDLE;            // R19
                end
            end
            // Sleep pin low until the request drops
            pni_pkg::ST_SLEEP: begin
                if (!sleep_i) begin
                    next_cur.sleep_n = 1'b1;                      // R14
                    next_cur.cnt     = pni_pkg::WAKE_CYC;
                    next_cur.state   = pni_pkg::ST_WAKE;
                end
            end
            // No access until the wake delay has passed
            pni_pkg::ST_WAKE: begin
                next_cur.cnt = cur.cnt - pni_pkg::CNT_ONE;
                if (cur.cnt == pni_pkg::CNT_ONE) begin
                    next_cur.state = pni_pkg::ST_IDLE;            // R14
                end
            end
        endcase
        // Ready never overlaps the answer, so a held request is not taken twice
        next_cur.ready = !next_cur.ack && !sleep_i &&
                         ((next_cur.state == pni_pkg::ST_IDLE) ||
                          (next_cur.state == pni_pkg::ST_OPEN));
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur          <= '0;
            cur.state    <= pni_pkg::ST_IDLE;
            cur.cs_n     <= 1'b1;
            cur.we_n     <= 1'b1;
            cur.oe_n     <= 1'b1;                                 // R9
            cur.ub_n     <= 1'b1;
            cur.lb_n     <= 1'b1;
            cur.sleep_n  <= 1'b1;                                 // R14
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs straight from flops, asleep_o through an inverter on the sleep flop
    // ************************************************************
    assign ready_o               = cur.ready;
    assign ack_o                 = cur.ack;
    assign rdata_o               = cur.rdata;
    assign asleep_o              = ~cur.sleep_n;
    assign word_address_lines_o  = cur.addr;
    assign chip_select_n_o       = cur.cs_n;
    assign write_strobe_n_o      = cur.we_n;
    assign output_drive_n_o      = cur.oe_n;
    assign upper_byte_select_n_o = cur.ub_n;
    assign lower_byte_select_n_o = cur.lb_n;
    assign sleep_request_n_o     = cur.sleep_n;
    assign data_lines_o          = cur.wdata;
    assign data_lines_oe_o       = cur.doe;                       // R3

endmodule : pni_host
`default_nettype wire

//--- logic/pni_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pni_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule : pni_sync
`default_nettype wire
